// file: inc/mabp_defs.svh
// Constants of the multiplexed address/data bus port
`ifndef MABP_DEFS_SVH
`define MABP_DEFS_SVH

// ****************************************************************
// Memory port width codes
// ****************************************************************
`define MABP_PW_WORD     2'h0
`define MABP_PW_HALF     2'h1
`define MABP_PW_BYTE     2'h2

// ****************************************************************
// Datum size codes
// ****************************************************************
`define MABP_SZ_BYTE     2'h0
`define MABP_SZ_HALF     2'h1
`define MABP_SZ_WORD     2'h2

// ****************************************************************
// Reset configuration pin positions on the low address pins
// ****************************************************************
`define MABP_CFG_BYTE    3
`define MABP_CFG_HALF    2
`define MABP_CFG_RSVD    1
`define MABP_CFG_HOLD    0

// ****************************************************************
// Reset values and timing counts
// ****************************************************************
`define MABP_STROBE_OFF  4'hF
`define MABP_HOLD_BASE   2'h1
`define MABP_BURST_ADDR  4'h0
`define MABP_BUF_DEPTH   2'h2

`endif

// file: inc/mabp_pkg.sv
// Types of the multiplexed address/data bus port
package mabp_pkg;

  // Bus sequencer states
  typedef enum logic [2:0] {
    MABP_IDLE,
    MABP_ADDR,
    MABP_HOLD,
    MABP_WDATA,
    MABP_RDATA,
    MABP_TURN
  } mabp_phase_t;

  // One transfer request from the caches or the write buffer
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] wdata;
    logic [1:0]  size;
    logic [1:0]  portWidth;
    logic        write;
    logic        iMiss;
    logic        dMiss;
  } mabp_req_t;

  // One word handed to the read buffer consumer
  typedef struct packed {
    logic [31:0] data;
    logic        last;
  } mabp_word_t;

  // Whole state of the port
  typedef struct packed {
    mabp_phase_t st;
    mabp_req_t   req;
    logic        burst;
    logic [3:0]  lowAddr;
    logic [4:0]  beatsLeft;
    logic [1:0]  holdCnt;
    logic [31:0] acc;
    logic [31:0] adSync1;
    logic [31:0] adSync2;
    logic        ackSync1;
    logic        ackSync2;
    logic [3:0]  cfgSync1;
    logic [3:0]  cfgSync2;
    logic [3:0]  cfg;
    logic        ale;
    logic [31:0] adOut;
    logic        adOe;
    logic        rdEn;
    logic        busRead;
    logic        burstPin;
    logic        addrOe;
    mabp_word_t  buf0;
    mabp_word_t  buf1;
    logic [1:0]  bufCnt;
  } mabp_state_t;

endpackage : mabp_pkg

// file: src/mabp_port.sv
// Multiplexed address/data bus port with read buffer and reset straps
//
// Function
// (RULE_01) Bus timing references the driven output clock
// (RULE_02) Each transfer: address phase, then data phase
// (RULE_03) Address phase drives upper address bits
// (RULE_04) Address phase drives active-low byte lane strobes
// (RULE_05) Strobes meaningful only for word-wide ports
// (RULE_06) Control bit keeps strobes inactive on reads
// (RULE_07) Write data phase drives buffered store data
// (RULE_08) Reads take one word or four-word burst
// (RULE_09) Byte lanes follow size, port width, ordering
// (RULE_10) Low address bits valid per port width
// (RULE_11) Single transfers start at target, then advance
// (RULE_12) Burst reads count from zero by port width
// (RULE_13) Low address pins are straps during reset
// (RULE_14) Address latch strobe marks valid address
// (RULE_15) Read drive enable after bus release, reads only; here the enable rises on the same edge as the release
// (RULE_16) Burst on instruction misses, optional data misses
// (RULE_17) Strap pins return to outputs after reset
//
`timescale 1ns/100ps
`include "mabp_defs.svh"

module mabp_port
  import mabp_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rstn,
  // Request side, same clock
  input  wire logic        reqValid,
  output logic             reqReady,
  input  wire mabp_req_t   req,
  input  wire logic        bigEndian,
  input  wire logic        dataRefill4,
  input  wire logic        strobeReadOff,
  // Read buffer drain side
  output logic             rdValid,
  input  wire logic        rdReady,
  output mabp_word_t       rdWord,
  // Pins
  output logic             systemClockOutput,
  input  wire logic [31:0] adIn,
  output logic [31:0]      adOut,
  output logic             adOe,
  output logic             ale,
  output logic             readDriveEnable,
  output logic             busRead,
  output logic             burstReq,
  input  wire logic        memAck,
  output logic             memReady,
  input  wire logic [3:0]  addrIn,
  output logic [3:0]       addrOut,
  output logic             addrOe,
  // Captured reset options
  output logic             bootRomByteWideOption,
  output logic             bootRomHalfwordWideOption,
  output logic             reservedConfigHigh,
  output logic             extendedAddrHoldOption
);

  // ****************************************************************
  // Helper functions
  // ****************************************************************

  // Bytes moved per beat on a port of the given width
  function automatic logic [3:0] portBytes(input logic [1:0] pw);
    case (pw)
      `MABP_PW_BYTE: portBytes = 4'h1;
      `MABP_PW_HALF: portBytes = 4'h2;
      default:       portBytes = 4'h4;
    endcase
  endfunction : portBytes

  // Beats needed for a datum, or for a whole burst
  function automatic logic [4:0] beatCount(input logic [1:0] pw,
                                           input logic [1:0] size,
                                           input logic       burst);
    logic [4:0] r;
    r = 5'h1;
    if (burst)
    begin
      case (pw)
        `MABP_PW_BYTE: r = 5'h10;
        `MABP_PW_HALF: r = 5'h08;
        default:       r = 5'h04;
      endcase
    end
    else if (pw == `MABP_PW_BYTE)
    begin
      case (size)
        `MABP_SZ_WORD: r = 5'h04;
        `MABP_SZ_HALF: r = 5'h02;
        default:       r = 5'h01;
      endcase
    end
    else if (pw == `MABP_PW_HALF && size == `MABP_SZ_WORD)
      r = 5'h02;
    beatCount = r;
  endfunction : beatCount

  // Lanes touched by a datum on a word port; big endian mirrors lanes
  function automatic logic [3:0] laneMask(input logic [1:0] a,
                                          input logic [1:0] size,
                                          input logic       be);
    logic [1:0] lane;
    lane = be ? ~a : a;
    case (size)
      `MABP_SZ_BYTE: laneMask = 4'h1 << lane;
      `MABP_SZ_HALF: laneMask = 4'h3 << {lane[1], 1'b0};
      default:       laneMask = 4'hF;
    endcase
  endfunction : laneMask

  // Merge one read beat into the word being assembled
  function automatic logic [31:0] mergeRead(input logic [31:0] acc,
                                            input logic [31:0] ad,
                                            input logic [3:0]  a,
                                            input logic [1:0]  pw,
                                            input logic        be);
    logic [1:0]  lane;
    logic [31:0] r;
    lane = be ? ~a[1:0] : a[1:0];
    r = acc;
    case (pw)
      `MABP_PW_BYTE: r[{lane, 3'h0} +: 8] = be ? ad[31:24] : ad[7:0];
      `MABP_PW_HALF: r[{lane[1], 4'h0} +: 16] = be ? ad[31:16] : ad[15:0];
      default:       r = ad;
    endcase
    mergeRead = r;
  endfunction : mergeRead

  // Data for one write beat; on byte and halfword ports the beat is copied to every lane,
  // so the memory finds it on its lanes whatever the byte ordering
  function automatic logic [31:0] writeLanes(input logic [31:0] w,
                                             input logic [3:0]  a,
                                             input logic [1:0]  pw,
                                             input logic        be);
    logic [1:0] lane;
    lane = be ? ~a[1:0] : a[1:0];
    case (pw)
      `MABP_PW_BYTE: writeLanes = {4{w[{lane, 3'h0} +: 8]}};
      `MABP_PW_HALF: writeLanes = {2{w[{lane[1], 4'h0} +: 16]}};
      default:       writeLanes = w;
    endcase
  endfunction : writeLanes

  // ****************************************************************
  // State and next state
  // ****************************************************************

  mabp_state_t s;
  mabp_state_t next_s;

  logic        isBurst;
  logic [3:0]  strobes;
  logic [3:0]  nextLow;
  logic [31:0] merged;
  logic        push;
  logic        pop;
  mabp_word_t  pushWord;

  // Request decode for the address phase
  always_comb
  begin
    isBurst = ~req.write & (req.iMiss | (req.dMiss & dataRefill4)); // RULE_16
    strobes = ~laneMask(req.addr[1:0], req.size, bigEndian); // RULE_04 RULE_09
    if (~req.write && strobeReadOff)
      strobes = `MABP_STROBE_OFF; // RULE_06
  end

  // Sequencer, synchronisers and read buffer
  always_comb
  begin
    next_s   = s;
    push     = 1'b0;
    pushWord = '0;
    nextLow  = s.lowAddr + portBytes(s.req.portWidth);
    merged   = mergeRead(s.acc, s.adSync2, s.lowAddr,
                         s.req.portWidth, bigEndian);
    pop      = (s.bufCnt != 2'h0) && rdReady;
    // Pins cross two flops before anything looks at them
    next_s.adSync1  = adIn;
    next_s.adSync2  = s.adSync1;
    next_s.ackSync1 = memAck;
    next_s.ackSync2 = s.ackSync1;
    next_s.cfgSync1 = addrIn;
    next_s.cfgSync2 = s.cfgSync1;
    next_s.addrOe   = 1'b1; // RULE_17
    case (s.st)
      MABP_IDLE:
        if (reqValid)
        begin
          next_s.req       = req;
          next_s.burst     = isBurst;
          // Bursts count up from zero, singles start at the target
          next_s.lowAddr   = isBurst ? `MABP_BURST_ADDR
                                     : req.addr[3:0]; // RULE_11 RULE_12
          next_s.beatsLeft = beatCount(req.portWidth, req.size, isBurst);
          next_s.acc       = '0;
          next_s.ale       = 1'b1; // RULE_14
          next_s.adOe      = 1'b1;
          next_s.adOut     = {req.addr[31:4], strobes}; // RULE_02 RULE_03
          next_s.busRead   = ~req.write;
          next_s.burstPin  = isBurst;
          next_s.st        = MABP_ADDR;
        end
      MABP_ADDR:
      begin
        // Address stays on the bus after the latch strobe falls
        next_s.ale     = 1'b0;
        next_s.holdCnt = `MABP_HOLD_BASE +
                         {1'b0, s.cfg[`MABP_CFG_HOLD]};
        next_s.st      = MABP_HOLD;
      end
      MABP_HOLD:
        if (s.holdCnt > 2'h1)
          next_s.holdCnt = s.holdCnt - 2'h1;
        else if (s.req.write)
        begin
          next_s.adOut = writeLanes(s.req.wdata, s.lowAddr,
                                    s.req.portWidth, bigEndian); // RULE_07
          next_s.st    = MABP_WDATA;
        end
        else
        begin
          // Release the bus and let memory drive it on the same edge
          next_s.adOe = 1'b0;
          next_s.rdEn = 1'b1; // RULE_15
          next_s.st   = MABP_RDATA;
        end
      MABP_WDATA:
        if (s.ackSync2)
        begin
          if (s.beatsLeft == 5'h01)
          begin
            next_s.adOe    = 1'b0;
            next_s.busRead = 1'b0;
            next_s.st      = MABP_IDLE;
          end
          else
          begin
            next_s.lowAddr   = nextLow; // RULE_11
            next_s.beatsLeft = s.beatsLeft - 5'h01;
            next_s.adOut     = writeLanes(s.req.wdata, nextLow,
                                          s.req.portWidth, bigEndian);
          end
        end
      MABP_RDATA:
        if (s.ackSync2)
        begin
          // A word is done at its last byte lane or the final beat
          if (s.beatsLeft == 5'h01 ||
              (s.burst && nextLow[1:0] == 2'h0))
          begin
            push          = 1'b1; // RULE_08
            pushWord.data = merged;
            pushWord.last = (s.beatsLeft == 5'h01);
            next_s.acc    = '0;
          end
          else
            next_s.acc = merged;
          if (s.beatsLeft == 5'h01)
          begin
            next_s.rdEn     = 1'b0;
            next_s.busRead  = 1'b0;
            next_s.burstPin = 1'b0;
            next_s.st       = MABP_TURN;
          end
          else
          begin
            next_s.lowAddr   = nextLow; // RULE_12
            next_s.beatsLeft = s.beatsLeft - 5'h01;
          end
        end
      MABP_TURN:
        // One dead cycle so memory drivers turn off before we drive
        next_s.st = MABP_IDLE;
      default:
        next_s.st = MABP_IDLE;
    endcase
    // Two-entry read buffer, head in buf0
    case ({push, pop})
      2'h2:
      begin
        if (s.bufCnt == 2'h0)
          next_s.buf0 = pushWord;
        else
          next_s.buf1 = pushWord;
        next_s.bufCnt = s.bufCnt + 2'h1;
      end
      2'h1:
      begin
        next_s.buf0   = s.buf1;
        next_s.bufCnt = s.bufCnt - 2'h1;
      end
      2'h3:
      begin
        if (s.bufCnt == 2'h1)
          next_s.buf0 = pushWord;
        else
        begin
          next_s.buf0 = s.buf1;
          next_s.buf1 = pushWord;
        end
      end
      default:
        next_s.bufCnt = s.bufCnt;
    endcase
    // Straps are active low and are followed for as long as reset holds
    if (!rstn)
    begin
      next_s          = '0;
      next_s.st       = MABP_IDLE;
      next_s.adSync1  = adIn;
      next_s.adSync2  = s.adSync1;
      next_s.ackSync1 = memAck;
      next_s.ackSync2 = s.ackSync1;
      next_s.cfgSync1 = addrIn;
      next_s.cfgSync2 = s.cfgSync1;
      next_s.cfg      = ~s.cfgSync2; // RULE_13
      next_s.addrOe   = 1'b0; // RULE_13
    end
  end

  // State register, synchronous reset handled above
  always_ff @(posedge clk)
  begin
    s <= next_s;
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************

  // Inputs are sampled on the same edge that leaves as the bus clock
  assign systemClockOutput = clk; // RULE_01
  assign reqReady          = rstn && (s.st == MABP_IDLE);
  assign rdValid           = (s.bufCnt != 2'h0);
  assign rdWord            = s.buf0;
  assign memReady          = (s.st == MABP_RDATA) &&
                             (s.bufCnt != `MABP_BUF_DEPTH);
  assign adOut             = s.adOut;
  assign adOe              = s.adOe;
  assign ale               = s.ale;
  assign readDriveEnable   = s.rdEn;
  assign busRead           = s.busRead;
  assign burstReq          = s.burstPin;
  // Bits below the port width are don't-care for external logic
  assign addrOut           = s.lowAddr; // RULE_10
  assign addrOe            = s.addrOe;
  assign bootRomByteWideOption     = s.cfg[`MABP_CFG_BYTE];
  assign bootRomHalfwordWideOption = s.cfg[`MABP_CFG_HALF];
  assign reservedConfigHigh        = s.cfg[`MABP_CFG_RSVD];
  assign extendedAddrHoldOption    = s.cfg[`MABP_CFG_HOLD];

endmodule : mabp_port

// file: tb/mabp_port_sva.sv
// Concurrent assertions on the ports of the bus port
`timescale 1ns/100ps
`include "mabp_defs.svh"

module mabp_port_sva
  import mabp_pkg::*;
(
  input wire logic        clk,
  input wire logic        rstn,
  input wire logic        reqValid,
  input wire logic        reqReady,
  input wire mabp_req_t   req,
  input wire logic        dataRefill4,
  input wire logic        strobeReadOff,
  input wire logic        systemClockOutput,
  input wire logic [31:0] adOut,
  input wire logic        adOe,
  input wire logic        ale,
  input wire logic        readDriveEnable,
  input wire logic        busRead,
  input wire logic        burstReq,
  input wire logic        memReady,
  input wire logic [3:0]  addrOut,
  input wire logic        addrOe,
  input wire logic        bootRomByteWideOption,
  input wire logic        bootRomHalfwordWideOption,
  input wire logic        reservedConfigHigh,
  input wire logic        extendedAddrHoldOption
);
  logic       take;
  logic       bst;
  logic [3:0] opts;

  // ****************
  // Helper terms
  // ****************
  // Bursts on every instruction miss, on data misses only if enabled
  assign take = reqValid && reqReady;
  assign bst  = !req.write && (req.iMiss || (req.dMiss && dataRefill4));
  assign opts = {bootRomByteWideOption, bootRomHalfwordWideOption,
                 reservedConfigHigh, extendedAddrHoldOption};

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  // ****************
  // Properties
  // ****************
  // Output clock is clk itself, so it is high just before each fall
  clk_ref_a: assert property (@(negedge clk) systemClockOutput)
    else $error("clock output not following clk");
  addr_phase_a: assert property (
    take |=> ale && adOe && adOut[31:4] == $past(req.addr[31:4]))
    else $error("address phase wrong");
  word_strb_a: assert property (
    take && req.size == `MABP_SZ_WORD && req.portWidth == `MABP_PW_WORD
    && (req.write || !strobeReadOff) |=> adOut[3:0] == 4'h0)
    else $error("word strobes not all active");
  read_strb_a: assert property (
    take && !req.write && strobeReadOff |=> adOut[3:0] == 4'hF)
    else $error("read strobes not held inactive");
  ale_hold_a: assert property (
    ale |=> !ale && adOe && $stable(adOut))
    else $error("address not held after latch strobe");
  drive_en_a: assert property (
    readDriveEnable |-> !adOe && busRead)
    else $error("read drive enable while bus driven");
  mem_rdy_a: assert property (
    memReady |-> readDriveEnable)
    else $error("memory ready outside read data");
  burst_a: assert property (
    take && bst |=> burstReq && addrOut == 4'h0)
    else $error("burst not started at zero");
  single_a: assert property (
    take && !bst |=> !burstReq && addrOut == $past(req.addr[3:0]))
    else $error("single transfer start address wrong");
  // Reset itself is the subject here, so this one is never disabled
  strap_in_a: assert property (
    @(posedge clk) disable iff (1'b0) !$past(rstn) |-> !addrOe)
    else $error("low address driven during reset");
  strap_out_a: assert property (
    $past(rstn) |-> addrOe)
    else $error("low address not driven after reset");
  opt_hold_a: assert property (
    $past(rstn) |-> $stable(opts))
    else $error("reset options changed after release");
endmodule : mabp_port_sva

bind mabp_port mabp_port_sva chk (.clk, .rstn, .reqValid, .reqReady, .req,
  .dataRefill4, .strobeReadOff, .systemClockOutput, .adOut, .adOe, .ale,
  .readDriveEnable, .busRead, .burstReq, .memReady, .addrOut, .addrOe,
  .bootRomByteWideOption, .bootRomHalfwordWideOption, .reservedConfigHigh,
  .extendedAddrHoldOption);

// file: tb/mabp_mem_model.sv
// Behavioural memory and address latch beyond the bus port
`timescale 1ns/100ps

module mabp_mem_model (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        slow,
  input  wire logic        ale,
  input  wire logic [31:0] adOut,
  input  wire logic        adOe,
  input  wire logic        readDriveEnable,
  input  wire logic        busRead,
  input  wire logic        memReady,
  input  wire logic [3:0]  addrOut,
  output logic             memAck,
  output logic [31:0]      memAd,
  output logic [31:0]      latchAd,
  output logic [31:0]      wrData
);
  logic [2:0] gap;
  logic [1:0] hold;

  // ****************
  // Latch, acknowledge, data drive
  // ****************
  // Acks stay four or more cycles apart so the port sees each one
  always @(posedge clk)
  begin
    memAck <= 1'b0;
    if (hold != 2'h0)
      hold <= hold - 2'h1;
    else
      memAd <= ~memAd; // Released bus inverts every cycle once the hold runs out
    if (!rstn)
    begin
      gap <= 3'h0;
      hold <= 2'h0;
      memAd <= 32'h0;
    end
    else if (ale)
    begin
      latchAd <= adOut;
      gap <= 3'h2;
    end
    else if (gap != 3'h0)
      gap <= gap - 3'h1;
    else if (readDriveEnable && memReady && !adOe)
    begin
      memAd <= {8{addrOut}};
      memAck <= 1'b1;
      hold <= 2'h2;
      gap <= slow ? 3'h6 : 3'h3;
    end
    else if (adOe && !busRead)
    begin
      wrData <= adOut;
      memAck <= 1'b1;
      gap <= slow ? 3'h6 : 3'h3;
    end
  end
endmodule : mabp_mem_model

// file: tb/tb_top.sv
// Self-checking bench for the multiplexed address/data bus port
`timescale 1ns/100ps
`include "mabp_defs.svh"

module tb_top
  import mabp_pkg::*;
();
  // Flags: write, instruction miss, data miss, big endian,
  // strobes off on reads, four-word data refill
  typedef struct packed {
    logic [31:0] a;
    logic [1:0]  sz;
    logic [1:0]  pw;
    logic [5:0]  fl;
    logic [3:0]  st;
    logic [31:0] d0;
    logic [31:0] dl;
    logic [2:0]  nw;
  } mabp_row_t;

  localparam logic [31:0] WD = 32'hC35A96E1;
  localparam logic [1:0]  SB = `MABP_SZ_BYTE;
  localparam logic [1:0]  SH = `MABP_SZ_HALF;
  localparam logic [1:0]  SW = `MABP_SZ_WORD;
  localparam logic [1:0]  PW = `MABP_PW_WORD;
  localparam logic [1:0]  PH = `MABP_PW_HALF;
  localparam logic [1:0]  PB = `MABP_PW_BYTE;

  logic        clk, rstn, reqValid, reqReady, bigEndian, dataRefill4;
  logic        strobeReadOff, rdValid, rdReady, systemClockOutput, adOe;
  logic        ale, readDriveEnable, busRead, burstReq, memAck, memReady;
  logic        addrOe, slow, bootRomByteWideOption, reservedConfigHigh;
  logic        bootRomHalfwordWideOption, extendedAddrHoldOption;
  logic [31:0] adIn, adOut, memAd, latchAd, wrData;
  logic [3:0]  addrIn, addrOut, straps;
  mabp_req_t   req;
  mabp_word_t  rdWord;
  mabp_word_t  got[$];
  mabp_row_t   rows[12];
  int          nErrors, checkCount;

  mabp_port dut (.clk, .rstn, .reqValid, .reqReady, .req, .bigEndian,
    .dataRefill4, .strobeReadOff, .rdValid, .rdReady, .rdWord,
    .systemClockOutput, .adIn, .adOut, .adOe, .ale, .readDriveEnable,
    .busRead, .burstReq, .memAck, .memReady, .addrIn, .addrOut, .addrOe,
    .bootRomByteWideOption, .bootRomHalfwordWideOption,
    .reservedConfigHigh, .extendedAddrHoldOption);
  mabp_mem_model mem (.clk, .rstn, .slow, .ale, .adOut, .adOe,
    .readDriveEnable, .busRead, .memReady, .addrOut, .memAck, .memAd,
    .latchAd, .wrData);

  // ****************
  // Pins, clock, monitors
  // ****************
  // Shared pins resolve to whoever drives them
  assign adIn = adOe ? adOut : memAd;
  assign addrIn = addrOe ? addrOut : straps;
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk)
    if (rstn && rdValid && rdReady)
      got.push_back(rdWord);
  initial
  begin
    #100000;
    nErrors++;
    $display("BAD %0t watchdog", $time);
    closeOut();
  end

  // ****************
  // Tasks
  // ****************
  task chk(input logic ok, input string m);
    checkCount++;
    if (ok !== 1'b1)
    begin
      nErrors++;
      $display("BAD %0t %s", $time, m);
    end
  endtask : chk

  task closeOut;
    $display("errors %0d checks %0d", nErrors, checkCount);
    if (nErrors == 0 && checkCount > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : closeOut

  // Straps must be stable well before release to pass the sync flops
  task do_reset(input logic [3:0] s);
    @(posedge clk);
    straps <= s;
    rstn <= 1'b0;
    repeat (5) @(posedge clk);
    chk(addrOe === 1'b0, "strap pins driven");
    rstn <= 1'b1;
    repeat (2) @(posedge clk);
    chk(addrOe === 1'b1, "low address released");
    chk({bootRomByteWideOption, bootRomHalfwordWideOption,
         reservedConfigHigh, extendedAddrHoldOption} === ~s, "options");
  endtask : do_reset

  task run(input mabp_row_t w);
    @(posedge clk);
    req <= '{w.a, WD, w.sz, w.pw, w.fl[5], w.fl[4], w.fl[3]};
    {bigEndian, strobeReadOff, dataRefill4} <= w.fl[2:0];
    reqValid <= 1'b1;
    got.delete();
    do @(posedge clk); while (reqReady !== 1'b1);
    reqValid <= 1'b0;
    do @(posedge clk); while (reqReady !== 1'b1);
    repeat (4) @(posedge clk);
    chk(latchAd[31:4] === w.a[31:4], "address");
    if (w.pw === PW)
      chk(latchAd[3:0] === w.st, "strobes");
    if (w.fl[5] && w.sz === SW)
      chk(wrData === WD, "store data");
    if (!w.fl[5])
      chk(got.size() == w.nw && got[0].data === w.d0
          && got[0].last === (w.nw == 1)
          && got[got.size() - 1] === {w.dl, 1'b1}, "read data");
  endtask : run

  // ****************
  // Main sequence
  // ****************
  initial
  begin
    {rstn, reqValid, bigEndian, dataRefill4, strobeReadOff, slow} = '0;
    req = '0;
    rdReady = 1'b1;
    straps = 4'h5;
    nErrors = 0;
    checkCount = 0;
    rows = '{
      '{32'h10000000, SW, PW, 6'h20, 4'h0, WD, WD, 3'h0},
      '{32'h10000003, SB, PW, 6'h20, 4'h7, WD, WD, 3'h0},
      '{32'h10000003, SB, PW, 6'h24, 4'hE, WD, WD, 3'h0},
      '{32'h10000008, SW, PW, 6'h02, 4'hF, 32'h88888888, 32'h88888888, 3'h1},
      '{32'h10000004, SW, PW, 6'h10, 4'h0, 32'h0, 32'hCCCCCCCC, 3'h4},
      '{32'h10000004, SW, PW, 6'h09, 4'h0, 32'h0, 32'hCCCCCCCC, 3'h4},
      '{32'h10000004, SW, PW, 6'h08, 4'h0, 32'h44444444, 32'h44444444, 3'h1},
      '{32'h20000000, SW, PB, 6'h00, 4'h0, 32'h33221100, 32'h33221100, 3'h1},
      '{32'h20000000, SW, PB, 6'h04, 4'h0, 32'h00112233, 32'h00112233, 3'h1},
      '{32'h20000000, SW, PH, 6'h00, 4'h0, 32'h22220000, 32'h22220000, 3'h1},
      '{32'h10000002, SH, PW, 6'h20, 4'h3, WD, WD, 3'h0},
      '{32'h20000002, SH, PB, 6'h04, 4'h0, 32'h00002233, 32'h00002233, 3'h1}
    };
    do_reset(4'h5);
    foreach (rows[i])
      run(rows[i]);
    // Consumer stalls from the start of a burst with a slow memory; no word may be lost
    @(posedge clk);
    rdReady <= 1'b0;
    slow <= 1'b1;
    fork
      run(rows[4]);
      begin
        repeat (60) @(posedge clk);
        chk(memReady === 1'b0 && rdValid === 1'b1, "full buffer");
        rdReady <= 1'b1;
      end
    join
    do_reset(4'hA);
    run(rows[0]);
    run(rows[3]);
    closeOut();
  end
endmodule : tb_top
